/* design/ttf_defs.svh */
// constants for the trigger timing and forwarding register slice
// assumes an apb slave with 32-bit data, one register per aligned word
// Functional notes
// - high period bytes at 0x19/0x1a, reset zero
// - trigger high lasts high value plus one
// - low period bytes at 0x1b/0x1c, reset zero
// - trigger low lasts low value plus one
// - frame limit at 0x1d/0x1e, low resets 0x04
// - raw mode inserts frame number in packets
// - zero limit gives frame number always zero
// - nonzero limit counts one to limit, wraps
// - bit 3 of 0x1f selects internal oscillator
// - two-bit lane rate field, resets to 10
// - bits 7:4 of 0x20 disable forwarding, reset one
// - bits 3:1 of 0x20 route ports to output
// - split mode separate, equal mode 24-bit value
// - bit 0 of 0x20 routes port 0
`ifndef TTF_DEFS_SVH
`define TTF_DEFS_SVH

// register indices (printed offsets are not all multiples of four)
`define TTF_IDX_HIGH_UPPER  8'h19
`define TTF_IDX_HIGH_LOWER  8'h1a
`define TTF_IDX_LOW_UPPER   8'h1b
`define TTF_IDX_LOW_LOWER   8'h1c
`define TTF_IDX_LIMIT_UPPER 8'h1d
`define TTF_IDX_LIMIT_LOWER 8'h1e
`define TTF_IDX_CLOCK_CTRL  8'h1f
`define TTF_IDX_FWD_CTRL    8'h20
// own control register for trigger enable and duty mode
`define TTF_IDX_TRIG_CTRL   8'h21
// own status register for trigger level and frame number
`define TTF_IDX_STATUS      8'h22

// reset values
`define TTF_RST_HIGH        8'h00
`define TTF_RST_LOW         8'h00
`define TTF_RST_LIMIT_UPPER 8'h00
`define TTF_RST_LIMIT_LOWER 8'h04
`define TTF_RST_LANE_RATE   2'h2
`define TTF_RST_FWD_OFF     4'hf
`define TTF_RST_ROUTE       4'h0

// field positions
`define TTF_BIT_OSC_SEL     3
`define TTF_BIT_REF_MODE    2
`define TTF_BIT_TRIG_EN     0
`define TTF_BIT_DUTY_MODE   1

`endif

/* design/ttf_pkg.sv */
// types for the trigger timing and forwarding register slice
// assumes ttf_defs.svh supplies the numeric constants
package ttf_pkg;
    // trigger generator phase
    typedef enum logic [1:0] {
        TTF_IDLE = 2'b00,
        TTF_HIGH = 2'b01,
        TTF_LOW  = 2'b10
    } ttf_phase_t;

    // lane rate codes
    typedef enum logic [1:0] {
        TTF_RATE_1G5 = 2'b00,
        TTF_RATE_1G2 = 2'b01,
        TTF_RATE_800 = 2'b10,
        TTF_RATE_400 = 2'b11
    } ttf_rate_t;
endpackage

/* design/ttf_frame_counter.sv */
// frame number generator for raw-mode frame start and end packets
// assumes frameTick is a one-cycle pulse from same-clock logic
`timescale 1ns/100ps
module ttf_frame_counter (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        rawMode,     // raw receive mode active
    input  wire logic        frameTick,   // one pulse per frame
    input  wire logic [15:0] frameLimit,  // maximum frame count
    output logic      [15:0] frameNumber  // number put in packets
);
    // counts 1..limit then wraps; zero limit pins number at zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frameNumber <= 16'h0000;
        end else if (frameLimit == 16'h0000) begin
            frameNumber <= 16'h0000;
        end else if (rawMode && frameTick) begin
            // a shrunk limit below the count also wraps to one
            if (frameNumber >= frameLimit) begin
                frameNumber <= 16'h0001;
            end else begin
                frameNumber <= frameNumber + 16'h0001;
            end
        end
    end
endmodule // ttf_frame_counter

/* design/ttf_regs.sv */
// trigger timing, frame number limit, clock and forwarding registers
// assumes an apb master on clk_sys and a same-clock trigger timebase
`timescale 1ns/100ps
`include "ttf_defs.svh"
module ttf_regs (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timebaseTick,  // trigger timebase enable
    input  wire logic        rawMode,       // raw receive mode
    input  wire logic        frameTick,     // frame start pulse
    output logic             cameraTriggerPulse,
    output logic      [15:0] frameNumber,
    output logic             internalOscSelect,
    output logic             refClockHalf,
    output logic      [1:0]  laneRate,
    output logic      [3:0]  portForwardOff,
    output logic      [3:0]  portOutputRoute
);
    // stored register bytes
    logic [7:0]  highUpper_reg;           // high period bits 15:8
    logic [7:0]  highLower_reg;           // high period bits 7:0
    logic [7:0]  lowUpper_reg;            // low period bits 15:8
    logic [7:0]  lowLower_reg;            // low period bits 7:0
    logic [7:0]  limitUpper_reg;          // frame limit bits 15:8
    logic [7:0]  limitLower_reg;          // frame limit bits 7:0
    logic        trigEnable_reg;          // generator on
    logic        dutyMode_reg;            // 1 selects equal duty
    logic [23:0] periodCount_reg;         // timebase ticks left in phase
    ttf_pkg::ttf_phase_t phase_reg;       // generator phase
    ttf_pkg::ttf_phase_t phase_next;      // next phase
    logic [7:0]  wordIndex;               // register index from paddr
    logic        addrAligned;             // low address bits and bits 31:10 are zero
    logic        mapped;                  // index hits a register
    logic        setupWrite;              // write in access phase
    logic        accessDone;              // access phase this cycle
    logic [23:0] highLoad;                // high phase reload value
    logic [23:0] lowLoad;                 // low phase reload value
    logic [15:0] frameCount;              // counter output
    logic [31:0] readValue;               // read mux result

    // decode: byte address is four times the index
    assign wordIndex   = paddr[9:2];
    assign addrAligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
    assign mapped      = addrAligned &&
                         (wordIndex >= `TTF_IDX_HIGH_UPPER) &&
                         (wordIndex <= `TTF_IDX_STATUS);
    assign accessDone  = psel && penable;
    // only lane 0 carries the 8-bit registers
    assign setupWrite  = accessDone && pwrite && mapped && pstrb[0];

    // zero wait state answer; unmapped access reports slverr
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // ready pulses in the access cycle one after setup
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            highUpper_reg     <= `TTF_RST_HIGH;
            highLower_reg     <= `TTF_RST_HIGH;
            lowUpper_reg      <= `TTF_RST_LOW;
            lowLower_reg      <= `TTF_RST_LOW;
            limitUpper_reg    <= `TTF_RST_LIMIT_UPPER;
            limitLower_reg    <= `TTF_RST_LIMIT_LOWER;
            internalOscSelect <= 1'b0;
            refClockHalf      <= 1'b0;
            laneRate          <= `TTF_RST_LANE_RATE;
            portForwardOff    <= `TTF_RST_FWD_OFF;
            portOutputRoute   <= `TTF_RST_ROUTE;
            trigEnable_reg    <= 1'b0;
            dutyMode_reg      <= 1'b0;
        end else if (setupWrite && pready) begin
            case (wordIndex)
                `TTF_IDX_HIGH_UPPER: begin
                    highUpper_reg <= pwdata[7:0];
                end
                `TTF_IDX_HIGH_LOWER: begin
                    highLower_reg <= pwdata[7:0];
                end
                `TTF_IDX_LOW_UPPER: begin
                    lowUpper_reg <= pwdata[7:0];
                end
                `TTF_IDX_LOW_LOWER: begin
                    lowLower_reg <= pwdata[7:0];
                end
                `TTF_IDX_LIMIT_UPPER: begin
                    limitUpper_reg <= pwdata[7:0];
                end
                `TTF_IDX_LIMIT_LOWER: begin
                    limitLower_reg <= pwdata[7:0];
                end
                `TTF_IDX_CLOCK_CTRL: begin
                    // bits 7:4 are reserved and ignored
                    internalOscSelect <= pwdata[`TTF_BIT_OSC_SEL];
                    refClockHalf <= pwdata[`TTF_BIT_REF_MODE];
                    laneRate <= pwdata[1:0];
                end
                `TTF_IDX_FWD_CTRL: begin
                    portForwardOff  <= pwdata[7:4];
                    // bits 3:1 route ports 3..1, bit 0 routes port 0
                    portOutputRoute <= pwdata[3:0];
                end
                `TTF_IDX_TRIG_CTRL: begin
                    trigEnable_reg <= pwdata[`TTF_BIT_TRIG_EN];
                    dutyMode_reg   <= pwdata[`TTF_BIT_DUTY_MODE];
                end
                default: begin
                    // status index is read-only
                end
            endcase
        end
    end

    // reload values; equal duty takes a 24-bit value for both phases
    always_comb begin
        if (dutyMode_reg) begin
            highLoad = {highLower_reg, lowUpper_reg, lowLower_reg};
            lowLoad  = {highLower_reg, lowUpper_reg, lowLower_reg};
        end else begin
            highLoad = {8'h00, highUpper_reg, highLower_reg};
            lowLoad  = {8'h00, lowUpper_reg, lowLower_reg};
        end
    end

    // next phase: a phase ends when its count is spent on a tick
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            ttf_pkg::TTF_IDLE: begin
                if (trigEnable_reg) begin
                    phase_next = ttf_pkg::TTF_HIGH;
                end
            end
            ttf_pkg::TTF_HIGH: begin
                if (!trigEnable_reg) begin
                    phase_next = ttf_pkg::TTF_IDLE;
                end else if (timebaseTick && periodCount_reg == 24'h0) begin
                    phase_next = ttf_pkg::TTF_LOW;
                end
            end
            ttf_pkg::TTF_LOW: begin
                if (!trigEnable_reg) begin
                    phase_next = ttf_pkg::TTF_IDLE;
                end else if (timebaseTick && periodCount_reg == 24'h0) begin
                    phase_next = ttf_pkg::TTF_HIGH;
                end
            end
            default: begin
                phase_next = ttf_pkg::TTF_IDLE;
            end
        endcase
    end

    // phase register and period counter; value n lasts n+1 ticks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg       <= ttf_pkg::TTF_IDLE;
            periodCount_reg <= 24'h0;
        end else begin
            phase_reg <= phase_next;
            if (phase_next == ttf_pkg::TTF_HIGH &&
                phase_reg != ttf_pkg::TTF_HIGH) begin
                periodCount_reg <= highLoad;
            end else if (phase_next == ttf_pkg::TTF_LOW &&
                         phase_reg != ttf_pkg::TTF_LOW) begin
                periodCount_reg <= lowLoad;
            end else if (timebaseTick && periodCount_reg != 24'h0) begin
                periodCount_reg <= periodCount_reg - 24'h1;
            end
        end
    end

    // trigger output straight from a flip-flop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cameraTriggerPulse <= 1'b0;
        end else begin
            cameraTriggerPulse <= (phase_next == ttf_pkg::TTF_HIGH);
        end
    end

    // frame numbering for raw-mode packets
    ttf_frame_counter u_frame (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .rawMode     (rawMode),
        .frameTick   (frameTick),
        .frameLimit  ({limitUpper_reg, limitLower_reg}),
        .frameNumber (frameCount)
    );

    // registered copy keeps the output straight from a flip-flop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frameNumber <= 16'h0000;
        end else begin
            frameNumber <= frameCount;
        end
    end

    // read mux; unmapped and reserved bits read as zero
    always_comb begin
        readValue = 32'h0;
        case (wordIndex)
            `TTF_IDX_HIGH_UPPER:  readValue = {24'h0, highUpper_reg};
            `TTF_IDX_HIGH_LOWER:  readValue = {24'h0, highLower_reg};
            `TTF_IDX_LOW_UPPER:   readValue = {24'h0, lowUpper_reg};
            `TTF_IDX_LOW_LOWER:   readValue = {24'h0, lowLower_reg};
            `TTF_IDX_LIMIT_UPPER: readValue = {24'h0, limitUpper_reg};
            `TTF_IDX_LIMIT_LOWER: readValue = {24'h0, limitLower_reg};
            `TTF_IDX_CLOCK_CTRL: begin
                readValue = {28'h0, internalOscSelect, refClockHalf,
                             laneRate};
            end
            `TTF_IDX_FWD_CTRL: begin
                readValue = {24'h0, portForwardOff, portOutputRoute};
            end
            `TTF_IDX_TRIG_CTRL: begin
                readValue = {30'h0, dutyMode_reg, trigEnable_reg};
            end
            `TTF_IDX_STATUS: begin
                readValue = {15'h0, cameraTriggerPulse, frameNumber};
            end
            default: readValue = 32'h0;
        endcase
        if (!mapped) begin
            readValue = 32'h0;
        end
    end

    // read data registered alongside pready
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= readValue;
        end
    end
endmodule // ttf_regs

/* dv/ttf_regs_asserts.sv */
// assertions for the trigger timing and forwarding register slice
// assumes it is bound to ttf_regs and sees only that module's ports
`timescale 1ns/100ps
module ttf_regs_asserts (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        frameTick,
    input wire logic        cameraTriggerPulse,
    input wire logic [15:0] frameNumber,
    input wire logic        internalOscSelect,
    input wire logic        refClockHalf,
    input wire logic [1:0]  laneRate,
    input wire logic [3:0]  portForwardOff,
    input wire logic [3:0]  portOutputRoute
);
    logic wr;  // a lane 0 write completing at this edge, mapped or not
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_ready_after_setup: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_one_pulse: assert property ( // access phase ends at once
        pready |=> !pready) else $error("ready held too long");
    a_reset_values: assert property (
        $rose(reset_n) |-> laneRate == 2'h2 && portForwardOff == 4'hf
        && portOutputRoute == 4'h0) else $error("bad reset value");
    a_clock_write: assert property (
        wr && paddr == 32'h7c |=> internalOscSelect == $past(pwdata[3])
        && refClockHalf == $past(pwdata[2])
        && laneRate == $past(pwdata[1:0])) else $error("clock ctl write");
    a_fwd_write: assert property (
        wr && paddr == 32'h80 |=> portForwardOff == $past(pwdata[7:4])
        && portOutputRoute == $past(pwdata[3:0])) else $error("fwd write");
    a_config_hold: assert property (
        !wr |=> $stable(laneRate) && $stable(portForwardOff)
        && $stable(portOutputRoute)) else $error("config moved");
    a_frame_hold: assert property (
        !frameTick && !psel && !$past(psel) |=> ##1 $stable(frameNumber))
        else $error("frame number moved without tick");
    a_frame_step: assert property (
        $changed(frameNumber) |-> frameNumber <= 16'h1
        || frameNumber == $past(frameNumber) + 16'h1)
        else $error("frame number skipped");
    a_bad_addr: assert property ( // unmapped space
        psel && penable && pready && paddr > 32'h88 |-> pslverr
        && (pwrite || prdata == 32'h0)) else $error("unmapped access");
    a_trig_off: assert property (
        wr && paddr == 32'h84 && !pwdata[0] |-> ##[1:2] !cameraTriggerPulse)
        else $error("trigger not stopped");
endmodule // ttf_regs_asserts

bind ttf_regs ttf_regs_asserts i_ttf_regs_asserts (.clk_sys, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .frameTick, .cameraTriggerPulse, .frameNumber,
    .internalOscSelect, .refClockHalf, .laneRate, .portForwardOff,
    .portOutputRoute);

/* dv/tb_top.sv */
// self-checking bench for the trigger timing and forwarding registers
// assumes ttf_regs answers apb with no wait states
`timescale 1ns/100ps
module tb_top;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
    logic        timebaseTick, slowTick, rawMode, frameTick, err;
    logic        cameraTriggerPulse, internalOscSelect, refClockHalf;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] frameNumber;
    logic [3:0]  pstrb, portForwardOff, portOutputRoute;
    logic [1:0]  laneRate;
    int          miscompares, tests_run, hi, lo;
    // reset values and write patterns, one per register 0x64..0x80
    logic [7:0]  rstv [8] = '{0, 0, 0, 0, 0, 8'h04, 8'h02, 8'hf0};
    logic [7:0]  wrv [8] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h00, 8'h34,
                             8'h0b, 8'hf5};

    ttf_regs i_ttf_regs (.clk_sys, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .timebaseTick,
        .rawMode, .frameTick, .cameraTriggerPulse, .frameNumber,
        .internalOscSelect, .refClockHalf, .laneRate, .portForwardOff,
        .portOutputRoute);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // timebase ticks every cycle, or every other one to stretch periods
    always @(posedge clk_sys) timebaseTick <= slowTick ? ~timebaseTick : 1'b1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);  // let the commit edge land before port checks
    endtask
    // one full high then low phase of the trigger, counted in cycles
    task automatic meas();
        while (cameraTriggerPulse !== 1'b0) @(posedge clk_sys);
        while (cameraTriggerPulse !== 1'b1) @(posedge clk_sys);
        for (hi = 0; cameraTriggerPulse === 1'b1; hi++) @(posedge clk_sys);
        for (lo = 0; cameraTriggerPulse === 1'b0; lo++) @(posedge clk_sys);
    endtask
    // a single frame pulse; the number shows two cycles later
    task automatic frame(input logic [15:0] exp);
        @(posedge clk_sys);
        frameTick <= 1'b1;
        @(posedge clk_sys);
        frameTick <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(frameNumber, exp);
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        {reset_n, psel, penable, pwrite, rawMode, frameTick, slowTick} = '0;
        {paddr, pwdata, miscompares, tests_run} = '0;
        pstrb = 4'hf;
        timebaseTick = 1'b1;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 32'(32'h64 + 4 * i), 32'h0);
            chk(rd, rstv[i]);
        end
        for (int i = 0; i < 8; i++) apb(1'b1, 32'(32'h64 + 4 * i), wrv[i]);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 32'(32'h64 + 4 * i), 32'h0);
            chk(rd, wrv[i]);
        end
        chk({internalOscSelect, refClockHalf, laneRate}, 4'hb);
        chk({portForwardOff, portOutputRoute}, 8'hf5);
        apb(1'b1, 32'h80, 32'h05);
        chk(portForwardOff, 4'h0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 32'h7c, 32'(c));
            chk(laneRate, 32'(c));
        end
        apb(1'b1, 32'h7c, 32'h0c);
        chk({internalOscSelect, refClockHalf}, 2'b11);
        // unmapped, misaligned and strobe-less accesses change nothing
        apb(1'b0, 32'h8c, 32'h0);
        chk(err, 1'b1); // unmapped index reports an error
        chk(rd, 32'h0); // unmapped index reads zero
        apb(1'b1, 32'h65, 32'h77);
        chk(err, 1'b1);
        pstrb <= 4'h0;
        apb(1'b1, 32'h64, 32'h77);
        pstrb <= 4'hf;
        apb(1'b0, 32'h64, 32'h0);
        chk(rd, 8'ha5);
        // trigger: high 2, low 1, split mode
        apb(1'b1, 32'h64, 32'h0);
        apb(1'b1, 32'h68, 32'h2);
        apb(1'b1, 32'h6c, 32'h0);
        apb(1'b1, 32'h70, 32'h1);
        apb(1'b1, 32'h84, 32'h1);
        meas();
        chk(hi, 3);
        chk(lo, 2);
        apb(1'b1, 32'h68, 32'h0);
        meas();
        chk(hi, 1);
        slowTick <= 1'b1;
        meas();
        chk({hi[15:0], lo[15:0]}, {16'd2, 16'd4});
        slowTick <= 1'b0;
        apb(1'b1, 32'h84, 32'h3);  // equal duty from 24-bit value 1
        meas();
        chk({hi[15:0], lo[15:0]}, {16'd2, 16'd2});
        apb(1'b1, 32'h84, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk(cameraTriggerPulse, 1'b0);
        // frame numbers with limit 3, then limit 0
        apb(1'b1, 32'h74, 32'h0);
        apb(1'b1, 32'h78, 32'h3);
        frame(16'h0);
        rawMode <= 1'b1;
        for (int i = 0; i < 5; i++) frame(16'(i % 3 + 1));
        apb(1'b1, 32'h78, 32'h0);
        frame(16'h0);
        close_out();
    end
    // watchdog: the whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end
endmodule // tb_top
